/* design/zsr_recloser.sv */
// Zero sequence recloser control with APB registers, event output and operation log.
// Assumes all inputs synchronous to SYS_CLK and the protection wired as its partner expects.
//
// Overview of operation
// (RL1) Enable low: assert disabled output and never command a breaker close.
// (RL2) A neutral overvoltage trip asserts the active output until the fault clears.
// (RL3) Close command only after a trip and after the full reclose delay.
// (RL4) After reclosing, hold the overvoltage-block output until the fault clears.
// (RL5) Protection block input is driven by our block output and breaker-open status.
// (RL6) Trip and blocked inputs come from the protection's trip and blocked signals.
// (RL7) Persisting fault raises protection blocked; our block output follows it.
// (RL8) After reclosing, protection and recloser stay blocked until the fault clears.
// (RL9) Report condition: normal, requested, blocked, active, close issued, closed blocked.
// (RL10) Report logical node mode: on, blocked, test, test-and-blocked, off.
// (RL11) Emit time-stamped on/off events for request, blocked, active, close, blocking.
// (RL12) Per event, configuration picks whether on, off or both transitions are stored.
// (RL13) Keep a circular log of the twelve most recent time-stamped entries.
// (RL14) Log only on the on transition of the close and blocked events.
// (RL15) Entry holds ms time stamp, event, setting group, time before close, been active.
// (RL16) Delay set in 5 ms steps; blocked input must stay active throughout.
// (RL17) Blocked input starts the countdown; the close follows when the delay passes.
// (RL18) Operating delay taken from one of eight setting groups, changeable while running.
// (RL19) Fault cleared when trip and blocked are both low; release outputs, go normal.
// (RL20) Blocked input dropping early abandons the countdown and reloads the timer.
//
// The APB register port and the placing of the registers were left to the implementer.
`default_nettype none
module zsr_recloser #(
    parameter int unsigned STEP_CYCLES = zsr_pkg::STEP_CYCLES,
    parameter int unsigned MS_CYCLES = zsr_pkg::MS_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic ENABLE_IN,
    input wire logic NEUTRAL_OV_TRIP,
    input wire logic NEUTRAL_OV_BLOCKED_IND,
    output logic RECLOSER_DISABLED_OUT,
    output logic RECLOSER_ACTIVE_OUT,
    output logic BREAKER_CLOSE_CMD,
    output logic NEUTRAL_OV_BLOCK_OUT,
    output zsr_pkg::zsr_event_type EVENT_OUT
);
    zsr_pkg::zsr_cond_type state_reg, state_next;
    zsr_pkg::zsr_mode_type mode_reg;
    zsr_pkg::zsr_log_entry_type log_wr_data, log_rd_data;
    zsr_pkg::zsr_event_type evt_reg, evt_next;
    logic [2:0] group_reg;
    logic [9:0] mask_reg;
    logic [3:0] log_sel_reg;
    logic [zsr_pkg::DELAY_W-1:0] delay_reg [zsr_pkg::NUM_GROUPS];
    logic [zsr_pkg::DELAY_W-1:0] tmr_remain;
    logic tmr_run, tmr_expired, dis, log_wr, been_active_reg;
    logic [3:0] log_count, slot;
    logic [14:0] ms_pre_reg;
    logic [31:0] stamp_reg;
    logic [4:0] lvl, lvl_prev_reg;
    logic [9:0] pend_reg, pend_next, new_evt;
    logic [31:0] prdata_reg, rdata;
    logic pready_reg, pslverr_reg, apb_wr;
    logic dis_reg, act_reg, close_reg, ovblk_reg;

    // Mapped register check, shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a == zsr_pkg::OFS_CONFIG || a == zsr_pkg::OFS_STATUS ||
            a == zsr_pkg::OFS_LOG_SEL || a == zsr_pkg::OFS_LOG_STAMP ||
            a == zsr_pkg::OFS_LOG_INFO || a == zsr_pkg::OFS_TIME ||
            (a[7:5] == zsr_pkg::OFS_DELAY0[7:5] && a[1:0] == 2'h0);
    endfunction

    // Lowest pending event slot; even slots are on, odd slots off
    function automatic logic [3:0] first_set(input logic [9:0] v);
        first_set = 4'hF;
        for (int i = 9; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // Mode blocked, test-blocked and off disable the function like a low enable
    assign dis = !ENABLE_IN || mode_reg == zsr_pkg::MODE_BLOCKED || // RL1 RL10
        mode_reg == zsr_pkg::MODE_TEST_BLOCKED || mode_reg == zsr_pkg::MODE_OFF;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            zsr_pkg::COND_NORMAL: begin
                if (NEUTRAL_OV_TRIP) begin
                    state_next = zsr_pkg::COND_ACTIVE; // RL2 RL6
                end
            end
            zsr_pkg::COND_ACTIVE: begin
                if (NEUTRAL_OV_BLOCKED_IND) begin
                    state_next = zsr_pkg::COND_REQUESTED; // RL7 RL17
                end else if (!NEUTRAL_OV_TRIP) begin
                    state_next = zsr_pkg::COND_NORMAL; // RL19
                end
            end
            zsr_pkg::COND_REQUESTED: begin
                if (!NEUTRAL_OV_BLOCKED_IND) begin
                    state_next = NEUTRAL_OV_TRIP ? zsr_pkg::COND_ACTIVE : // RL20
                        zsr_pkg::COND_NORMAL;
                end else if (tmr_expired) begin
                    state_next = zsr_pkg::COND_CLOSE_CMD; // RL3 RL16
                end
            end
            zsr_pkg::COND_CLOSE_CMD: begin
                state_next = zsr_pkg::COND_CLOSED_OV_BLK; // RL4
            end
            zsr_pkg::COND_CLOSED_OV_BLK: begin
                if (!NEUTRAL_OV_TRIP && !NEUTRAL_OV_BLOCKED_IND) begin
                    state_next = zsr_pkg::COND_NORMAL; // RL8 RL19
                end
            end
            zsr_pkg::COND_BLOCKED: begin
                state_next = zsr_pkg::COND_NORMAL;
            end
            default: begin
                state_next = zsr_pkg::COND_NORMAL;
            end
        endcase
        if (dis) begin
            state_next = zsr_pkg::COND_BLOCKED; // RL1
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_reg <= zsr_pkg::COND_NORMAL;
        end else begin
            state_reg <= state_next; // RL9
        end
    end

    // Outputs are registered from the next state so they line up with the condition
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            dis_reg <= 1'b0;
            act_reg <= 1'b0;
            close_reg <= 1'b0;
            ovblk_reg <= 1'b0;
        end else begin
            dis_reg <= state_next == zsr_pkg::COND_BLOCKED; // RL1
            act_reg <= state_next == zsr_pkg::COND_ACTIVE || // RL2
                state_next == zsr_pkg::COND_REQUESTED ||
                state_next == zsr_pkg::COND_CLOSE_CMD ||
                state_next == zsr_pkg::COND_CLOSED_OV_BLK;
            close_reg <= state_next == zsr_pkg::COND_CLOSE_CMD; // RL3
            ovblk_reg <= state_next == zsr_pkg::COND_REQUESTED || // RL4 RL5 RL7 RL8
                state_next == zsr_pkg::COND_CLOSE_CMD ||
                state_next == zsr_pkg::COND_CLOSED_OV_BLK;
        end
    end

    assign RECLOSER_DISABLED_OUT = dis_reg;
    assign RECLOSER_ACTIVE_OUT = act_reg;
    assign BREAKER_CLOSE_CMD = close_reg;
    assign NEUTRAL_OV_BLOCK_OUT = ovblk_reg;

    // Countdown runs only while requested and the blocked indication holds
    assign tmr_run = state_reg == zsr_pkg::COND_REQUESTED && NEUTRAL_OV_BLOCKED_IND; // RL16 RL20

    zsr_delay_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .clk(SYS_CLK),
        .rst(SRST),
        .run(tmr_run),
        .load_steps(delay_reg[group_reg]), // RL18
        .remain(tmr_remain),
        .expired(tmr_expired)
    );

    // Millisecond time base for stamps
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ms_pre_reg <= 15'h0000;
            stamp_reg <= 32'h00000000;
        end else if (ms_pre_reg == 15'(MS_CYCLES - 1)) begin
            ms_pre_reg <= 15'h0000;
            stamp_reg <= stamp_reg + 32'h00000001;
        end else begin
            ms_pre_reg <= ms_pre_reg + 15'h0001;
        end
    end

    // Event levels: request, blocked, active, close, overvoltage blocking
    assign lvl = {ovblk_reg, close_reg, act_reg, dis_reg,
        state_reg == zsr_pkg::COND_REQUESTED};

    generate
        for (genvar i = 0; i < zsr_pkg::NUM_EVT; i++) begin : g_evt
            assign new_evt[2*i] = lvl[i] && !lvl_prev_reg[i] && mask_reg[2*i]; // RL11 RL12
            assign new_evt[2*i+1] = !lvl[i] && lvl_prev_reg[i] && mask_reg[2*i+1]; // RL12
        end
    endgenerate

    // New events win over the slot being served, so none is lost
    always_comb begin
        pend_next = pend_reg;
        evt_next = '{valid: 1'b0, code: 3'h0, is_on: 1'b0, stamp: stamp_reg};
        slot = first_set(pend_reg);
        if (slot != 4'hF) begin
            evt_next.valid = 1'b1;
            evt_next.code = slot[3:1];
            evt_next.is_on = !slot[0];
            pend_next[slot] = 1'b0;
        end
        pend_next = pend_next | new_evt; // RL11
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            lvl_prev_reg <= 5'h00;
            pend_reg <= 10'h000;
            evt_reg <= '0;
        end else begin
            lvl_prev_reg <= lvl;
            pend_reg <= pend_next;
            evt_reg <= evt_next;
        end
    end

    assign EVENT_OUT = evt_reg;

    // Log writes ignore the event mask; they track the close and blocked on edges
    assign log_wr = (close_reg && !lvl_prev_reg[3]) || (dis_reg && !lvl_prev_reg[1]); // RL14
    assign log_wr_data = '{stamp: stamp_reg, is_close: close_reg, group: group_reg, // RL15
        remain: tmr_remain, been_active: been_active_reg || act_reg};

    always_ff @(posedge SYS_CLK) begin
        if (SRST || log_wr) begin
            been_active_reg <= 1'b0;
        end else if (act_reg) begin
            been_active_reg <= 1'b1;
        end
    end

    zsr_op_log u_log (
        .clk(SYS_CLK),
        .rst(SRST),
        .wr_en(log_wr), // RL13
        .wr_data(log_wr_data),
        .rd_idx(log_sel_reg),
        .rd_data(log_rd_data),
        .count(log_count)
    );

    // APB: one wait state; writes land on the edge that samples PREADY high
    assign apb_wr = PSEL && PENABLE && pready_reg && PWRITE && reg_hit(PADDR);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            mode_reg <= zsr_pkg::MODE_ON;
            group_reg <= 3'h0;
            mask_reg <= zsr_pkg::MASK_RESET;
            log_sel_reg <= 4'h0;
        end else if (apb_wr && PADDR == zsr_pkg::OFS_CONFIG) begin
            mode_reg <= (PWDATA[zsr_pkg::CFG_MODE_LSB+:3] > 3'h4) ? zsr_pkg::MODE_OFF :
                zsr_pkg::zsr_mode_type'(PWDATA[zsr_pkg::CFG_MODE_LSB+:3]); // RL10
            group_reg <= PWDATA[zsr_pkg::CFG_GROUP_LSB+:3]; // RL18
            mask_reg <= PWDATA[zsr_pkg::CFG_MASK_LSB+:10]; // RL12
        end else if (apb_wr && PADDR == zsr_pkg::OFS_LOG_SEL) begin
            log_sel_reg <= PWDATA[3:0];
        end
    end

    generate
        for (genvar g = 0; g < zsr_pkg::NUM_GROUPS; g++) begin : g_delay
            always_ff @(posedge SYS_CLK) begin
                if (SRST) begin
                    delay_reg[g] <= zsr_pkg::DELAY_RESET;
                end else if (apb_wr && PADDR == zsr_pkg::OFS_DELAY0 + 8'(4 * g)) begin
                    delay_reg[g] <= PWDATA[zsr_pkg::DELAY_W-1:0]; // RL16 RL18
                end
            end
        end
    endgenerate

    always_comb begin
        rdata = 32'h00000000;
        case (PADDR)
            zsr_pkg::OFS_CONFIG: rdata = {6'h00, mask_reg, 9'h000, group_reg, 1'b0, mode_reg};
            zsr_pkg::OFS_STATUS: rdata = {16'h0000, log_count, close_reg, ovblk_reg,
                act_reg, dis_reg, 1'b0, mode_reg, 1'b0, state_reg}; // RL9 RL10
            zsr_pkg::OFS_LOG_SEL: rdata = {28'h0000000, log_sel_reg};
            zsr_pkg::OFS_LOG_STAMP: rdata = log_rd_data.stamp;
            zsr_pkg::OFS_LOG_INFO: rdata = {8'h00, log_rd_data.been_active, log_rd_data.is_close,
                log_rd_data.group, log_rd_data.remain};
            zsr_pkg::OFS_TIME: rdata = stamp_reg;
            default: begin
                if (reg_hit(PADDR)) begin
                    rdata = {13'h0000, delay_reg[PADDR[4:2]]};
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= PSEL && PENABLE && !pready_reg;
            pslverr_reg <= PSEL && PENABLE && !pready_reg && !reg_hit(PADDR);
            if (PSEL && PENABLE && !pready_reg && !PWRITE) begin
                prdata_reg <= rdata;
            end
        end
    end

    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign PRDATA = prdata_reg;

    // Helper: consecutive cycles of a running countdown
    logic [31:0] run_cnt_reg;
    always_ff @(posedge SYS_CLK) begin
        if (SRST || !tmr_run) begin
            run_cnt_reg <= 32'h00000000;
        end else begin
            run_cnt_reg <= run_cnt_reg + 32'h00000001;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    chk_disabled_no_close: assert property (RECLOSER_DISABLED_OUT |-> !BREAKER_CLOSE_CMD) // RL1
        else $error("close while disabled");
    chk_enable_low_blocks: assert property (!ENABLE_IN |=> RECLOSER_DISABLED_OUT) // RL1
        else $error("enable low did not block");
    chk_trip_sets_active: assert property (state_reg == zsr_pkg::COND_NORMAL && // RL2
        NEUTRAL_OV_TRIP && !dis |=> RECLOSER_ACTIVE_OUT)
        else $error("trip did not set active");
    chk_close_after_delay: assert property ($rose(BREAKER_CLOSE_CMD) |-> // RL3
        $past(run_cnt_reg) >= 32'($past(delay_reg[group_reg])) * STEP_CYCLES)
        else $error("close before delay elapsed");
    chk_block_follows_ind: assert property (state_reg == zsr_pkg::COND_ACTIVE && // RL7
        NEUTRAL_OV_BLOCKED_IND && !dis |=> NEUTRAL_OV_BLOCK_OUT)
        else $error("block output did not follow");
    chk_block_after_close: assert property (BREAKER_CLOSE_CMD |=> // RL4
        NEUTRAL_OV_BLOCK_OUT && RECLOSER_ACTIVE_OUT && !BREAKER_CLOSE_CMD)
        else $error("no blocking after close");
    chk_closed_held: assert property (state_reg == zsr_pkg::COND_CLOSED_OV_BLK && // RL8
        (NEUTRAL_OV_TRIP || NEUTRAL_OV_BLOCKED_IND) && !dis |=> NEUTRAL_OV_BLOCK_OUT)
        else $error("blocking dropped with fault present");
    chk_clear_releases: assert property (state_reg == zsr_pkg::COND_CLOSED_OV_BLK && // RL19
        !NEUTRAL_OV_TRIP && !NEUTRAL_OV_BLOCKED_IND && !dis |=>
        !NEUTRAL_OV_BLOCK_OUT && !RECLOSER_ACTIVE_OUT)
        else $error("outputs not released on clear");
    chk_abandon_no_close: assert property (state_reg == zsr_pkg::COND_REQUESTED && // RL20
        !NEUTRAL_OV_BLOCKED_IND |=> !BREAKER_CLOSE_CMD ##1 tmr_remain == $past(delay_reg[group_reg]))
        else $error("countdown not abandoned");
    chk_log_on_close: assert property ($rose(BREAKER_CLOSE_CMD) |-> log_wr) // RL14
        else $error("close not logged");

    cov_close_issued: cover property ($rose(BREAKER_CLOSE_CMD));
    cov_countdown_abandoned: cover property (tmr_run ##1 !tmr_run && !BREAKER_CLOSE_CMD);
    cov_fault_cleared: cover property (state_reg == zsr_pkg::COND_CLOSED_OV_BLK ##1
        state_reg == zsr_pkg::COND_NORMAL);
endmodule
`default_nettype wire

/* design/zsr_pkg.sv */
// Package of the zero sequence recloser: register map, reset values, timing and types.
// Assumes a 25 MHz system clock and a 32-bit APB register port.
`default_nettype none
package zsr_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned STEP_TIME_US = 5000;
    localparam int unsigned STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_TIME_US;
    localparam int unsigned MS_TIME_US = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;
    localparam int unsigned DELAY_W = 19;
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned NUM_EVT = 5;
    localparam int unsigned LOG_DEPTH = 12;
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LOG_SEL = 8'h08;
    localparam logic [7:0] OFS_LOG_STAMP = 8'h0C;
    localparam logic [7:0] OFS_LOG_INFO = 8'h10;
    localparam logic [7:0] OFS_TIME = 8'h14;
    localparam logic [7:0] OFS_DELAY0 = 8'h20;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_GROUP_LSB = 4;
    localparam int unsigned CFG_MASK_LSB = 16;
    localparam logic [9:0] MASK_RESET = 10'h3FF;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 19'h000C8;
    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_REQUESTED = 3'h1,
        COND_BLOCKED = 3'h2,
        COND_ACTIVE = 3'h3,
        COND_CLOSE_CMD = 3'h4,
        COND_CLOSED_OV_BLK = 3'h5
    } zsr_cond_type;
    typedef enum logic [2:0] {
        MODE_ON = 3'h0,
        MODE_BLOCKED = 3'h1,
        MODE_TEST = 3'h2,
        MODE_TEST_BLOCKED = 3'h3,
        MODE_OFF = 3'h4
    } zsr_mode_type;
    typedef struct packed {
        logic [31:0] stamp;
        logic is_close;
        logic [2:0] group;
        logic [DELAY_W-1:0] remain;
        logic been_active;
    } zsr_log_entry_type;
    typedef struct packed {
        logic valid;
        logic [2:0] code;
        logic is_on;
        logic [31:0] stamp;
    } zsr_event_type;
endpackage
`default_nettype wire

/* design/zsr_delay_timer.sv */
// Reclose delay countdown in 5 ms steps.
// Assumes run stays high for the whole countdown; dropping it reloads the delay.
`default_nettype none
module zsr_delay_timer #(
    parameter int unsigned STEP_CYCLES = zsr_pkg::STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [zsr_pkg::DELAY_W-1:0] load_steps,
    output logic [zsr_pkg::DELAY_W-1:0] remain,
    output logic expired
);
    logic [17:0] pre_reg;
    logic [zsr_pkg::DELAY_W-1:0] remain_reg;

    // Prescaler restarts with every run so the delay is exact, not off by a step
    always_ff @(posedge clk) begin
        if (rst || !run || pre_reg == 18'(STEP_CYCLES - 1)) begin
            pre_reg <= 18'h00000;
        end else begin
            pre_reg <= pre_reg + 18'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            remain_reg <= zsr_pkg::DELAY_RESET;
        end else if (!run) begin
            remain_reg <= load_steps;
        end else if (pre_reg == 18'(STEP_CYCLES - 1) && remain_reg != '0) begin
            remain_reg <= remain_reg - 19'h00001;
        end
    end

    assign remain = remain_reg;
    assign expired = run && remain_reg == '0;
endmodule
`default_nettype wire

/* design/zsr_op_log.sv */
// Circular operation log of the last twelve entries, held in flip-flops.
// Read index 0 is the newest entry; older entries follow.
`default_nettype none
module zsr_op_log (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire zsr_pkg::zsr_log_entry_type wr_data,
    input wire logic [3:0] rd_idx,
    output zsr_pkg::zsr_log_entry_type rd_data,
    output logic [3:0] count
);
    zsr_pkg::zsr_log_entry_type mem_reg [zsr_pkg::LOG_DEPTH];
    logic [3:0] wptr_reg;
    logic [3:0] cnt_reg;
    logic [4:0] pos;

    always_ff @(posedge clk) begin
        if (rst) begin
            wptr_reg <= 4'h0;
            cnt_reg <= 4'h0;
        end else if (wr_en) begin
            wptr_reg <= (wptr_reg == 4'(zsr_pkg::LOG_DEPTH - 1)) ? 4'h0 : wptr_reg + 4'h1;
            if (cnt_reg != 4'(zsr_pkg::LOG_DEPTH)) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wptr_reg] <= wr_data;
        end
    end

    // Newest is one behind the write pointer, wrapping at twelve
    always_comb begin
        pos = 5'(wptr_reg) + 5'(zsr_pkg::LOG_DEPTH) - 5'h01 - 5'(rd_idx);
        if (pos >= 5'(zsr_pkg::LOG_DEPTH)) begin
            pos = pos - 5'(zsr_pkg::LOG_DEPTH);
        end
        if (rd_idx < cnt_reg && pos < 5'(zsr_pkg::LOG_DEPTH)) begin
            rd_data = mem_reg[pos[3:0]];
        end else begin
            rd_data = '0;
        end
    end

    assign count = cnt_reg;
endmodule
`default_nettype wire

/* tb/zsr_feeder_model.sv */
// Neutral overvoltage protection and circuit breaker of one feeder, behavioural.
// Assumes the recloser outputs are registered, so the combinational paths form no loop.
`default_nettype none
module zsr_feeder_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic fault,
    input wire logic block_out,
    input wire logic close_cmd,
    output logic trip,
    output logic blocked_ind
);
    timeunit 1ns;
    timeprecision 1ps;
    logic breaker_open_reg;
    logic block_in;
    // Breaker opens on trip and closes only on a close command
    always_ff @(posedge clk) begin
        if (rst) begin
            breaker_open_reg <= 1'b0;
        end else if (trip) begin
            breaker_open_reg <= 1'b1;
        end else if (close_cmd) begin
            breaker_open_reg <= 1'b0;
        end
    end
    assign block_in = block_out | breaker_open_reg;
    // Trip lasts until the breaker is seen open; blocked then takes over with no gap
    assign trip = fault & ~block_in;
    assign blocked_ind = fault & block_in;
endmodule
`default_nettype wire

/* tb/tb_zero_sequence_recloser.sv */
// Self-checking bench of the recloser: APB master, feeder model, random group and delay.
// Assumes short STEP_CYCLES and MS_CYCLES so a full reclose fits in a few hundred cycles.
`default_nettype none
module tb_zero_sequence_recloser;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 10;
    logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, q;
    logic pready, pslverr, err, enable_in = 1'b1, fault = 1'b0, trip, blocked_ind;
    logic [31:0] prdata;
    logic dis_out, act_out, close_cmd, block_out, seen_close_evt = 1'b0;
    zsr_pkg::zsr_event_type event_out;
    int num_errors = 0, n_compared = 0, n_close = 0, seed = 32'hA45199AC, d, g, n;
    always #20 sys_clk = ~sys_clk;
    zsr_recloser #(.STEP_CYCLES(STEP), .MS_CYCLES(5)) DUT (.SYS_CLK(sys_clk), .SRST(srst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENABLE_IN(enable_in),
        .NEUTRAL_OV_TRIP(trip), .NEUTRAL_OV_BLOCKED_IND(blocked_ind),
        .RECLOSER_DISABLED_OUT(dis_out), .RECLOSER_ACTIVE_OUT(act_out),
        .BREAKER_CLOSE_CMD(close_cmd), .NEUTRAL_OV_BLOCK_OUT(block_out), .EVENT_OUT(event_out));
    zsr_feeder_model feeder (.clk(sys_clk), .rst(srst), .fault(fault), .block_out(block_out),
        .close_cmd(close_cmd), .trip(trip), .blocked_ind(blocked_ind));
    always @(posedge sys_clk) begin
        if (close_cmd === 1'b1) n_close++;
        if (event_out.valid === 1'b1 && event_out.is_on === 1'b1 && event_out.code === 3'h3)
            seen_close_evt = 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin num_errors++; print_verdict(); end
        q = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    initial begin
        cycles(12);
        srst <= 1'b0;
        apb(1'b0, zsr_pkg::OFS_CONFIG, 0); chk(q, 32'h03FF0000);
        apb(1'b0, zsr_pkg::OFS_DELAY0, 0); chk(q, 32'h000000C8);
        apb(1'b0, 8'h18, 0); chk(err, 1'b1); // Unmapped place refuses
        chk(q, 32'h00000000);
        // Every mode, including an out-of-range code that must saturate to off
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, zsr_pkg::OFS_CONFIG, 32'h03FF0000 | m);
            apb(1'b0, zsr_pkg::OFS_STATUS, 0);
            d = (m > 4) ? 4 : m;
            chk({q[8], q[6:4]}, {d == 1 || d >= 3, d[2:0]});
            chk(dis_out, d == 1 || d >= 3);
        end
        g = $unsigned($random(seed)) % 8;
        d = 2 + $unsigned($random(seed)) % 4;
        apb(1'b1, zsr_pkg::OFS_CONFIG, 32'h03FF0000 | (g << 4));
        apb(1'b1, zsr_pkg::OFS_DELAY0 + 8'(4 * g), d);
        // Fault outside this feeder: trip, hold blocked, reclose after the full delay
        @(posedge sys_clk) fault <= 1'b1;
        cycles(3); chk(act_out, 1'b1);
        n = 0;
        do begin @(posedge sys_clk); n++; end while (close_cmd !== 1'b1 && n < 500);
        chk(n >= d * STEP && n <= d * STEP + 6, 1'b1);
        chk({act_out, block_out}, 2'b11);
        cycles(5); chk({close_cmd, act_out, block_out}, 3'b011);
        @(posedge sys_clk) fault <= 1'b0;
        cycles(4); chk({act_out, block_out}, 2'b00);
        // Two blocked-on entries from the mode sweep, then the close entry
        apb(1'b0, zsr_pkg::OFS_STATUS, 0); chk({q[15:12], q[2:0]}, {4'h3, 3'h0});
        // Newest entry: been active, close, group, nothing left of the delay
        apb(1'b0, zsr_pkg::OFS_LOG_INFO, 0); chk(q[23:0], {2'b11, g[2:0], 19'h00000});
        chk(seen_close_evt, 1'b1);
        // Fault clears before the delay runs out: no close
        n_close = 0;
        @(posedge sys_clk) fault <= 1'b1;
        cycles(8);
        fault <= 1'b0;
        cycles(d * STEP + 20); chk(n_close, 0);
        chk(act_out, 1'b0);
        // Enable low: disabled, blocked held by a persisting fault, still no close
        enable_in <= 1'b0;
        cycles(3); chk(dis_out, 1'b1);
        fault <= 1'b1;
        cycles(d * STEP + 20); chk(n_close, 0);
        print_verdict();
    end
    initial begin
        cycles(20000);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
